/* File: rtl/fast_count_consts.vh */
/*
  Constants of the fast count block: mode codes, widths, reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FAST_COUNT_CONSTS_VH
`define FAST_COUNT_CONSTS_VH
`define FC_MODE_ADD 2'h0
`define FC_MODE_UPDN 2'h1
`define FC_MODE_EDGE2 2'h2
`define FC_MODE_EDGE4 2'h3
`define FC_ACT_OUTPUT 1'h0
`define FC_ACT_IRQ 1'h1
`define FC_CNT_W 32
`define FC_CNT_RST 32'h00000000
`define FC_PRESET_RST 32'hFFFFFFFF
`define FC_GROUPS 6
`define FC_GROUPS_SMALL 4
`endif

/* File: rtl/fast_count_lane.v */
/*
  One counting lane: 32-bit current value with match detection.
  Assumes step, direction and clear come already synchronised on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fast_count_consts.vh"
module fast_count_lane #(
  parameter W = 32
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_step,
  input wire i_up,
  input wire i_clear,
  input wire [W-1:0] i_preset,
  output reg [W-1:0] o_value,
  output reg o_match
);
  reg [W-1:0] value_next;

  always @* begin
    value_next = o_value;
    if (i_clear)
      value_next = {W{1'b0}};
    else if (i_step && i_up)
      value_next = o_value + {{(W-1){1'b0}}, 1'b1};
    else if (i_step)
      value_next = o_value - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_value <= `FC_CNT_RST;
      o_match <= 1'b0;
    end else begin
      o_value <= value_next;
      // Compared against the next value so the match flag lines up with o_value
      o_match <= (value_next == i_preset);
    end
  end
endmodule // fast_count_lane
`default_nettype wire

/* File: rtl/fast_count_block.v */
/*
  Fast pulse counter: six input groups, single- or two-phase counting, preset compare.
  Assumes raw pins from field sources (synchronised here), config and presets static from software side.
*/
// Function
// - Pulses are counted by dedicated clocked hardware independent of any program scan.
// - Each counter's current value is compared continuously against its preset target.
// - On a match the block turns on the output or raises the interrupt request as configured.
// - The interrupt action is allowed only when ladder language is selected, else the output is used.
// - Modes are adding, up/down-select, 2-edge and 4-edge quadrature.
// - Large variants run up to six single-phase and two two-phase counters.
// - The small variant runs up to four single-phase and two two-phase counters.
// - Group 1 two-phase takes input 0 as A, input 1 as B, input 2 as clear.
// - Adding mode increments on every rising pulse edge.
// - Up/down mode counts up on a rising edge with direction high, down with it low.
// - 2-edge mode steps on both B edges, up when A leads, down when B leads.
// - 4-edge mode steps on both edges of both phases, up when A leads.
`timescale 1ns/1ps
`default_nettype none
`include "fast_count_consts.vh"
module fast_count_block #(
  parameter W = `FC_CNT_W,
  parameter SMALL_VARIANT = 0
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire [7:0] i_pins,
  input wire [1:0] i_mode_g1,
  input wire [1:0] i_mode_g3,
  input wire i_z_clear_en_g1,
  input wire i_z_clear_en_g3,
  input wire [5:0] i_enable,
  input wire [5:0] i_action,
  input wire i_ladder_lang,
  input wire [5:0] i_soft_clear,
  input wire [6*W-1:0] i_preset,
  input wire [5:0] i_out_release,
  output reg [6*W-1:0] o_value,
  output reg [5:0] o_cmp_out,
  output reg [5:0] o_irq
);
  // Lane order: group 1..6; pins 0..7 feed the lanes as per the input table
  // Six lanes are fixed by the input map; W only sets the counter width.
  // Field pins are asynchronous: two flip-flops before any logic reads them.
  // A third stage keeps the previous level for edge detection; it resets low
  // like the idle pins, so no false edge follows reset.
  // Cost: a pin edge reaches a counter three clocks late, harmless at field rates.
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] prev_reg;
  wire [7:0] rise = sync2_reg & ~prev_reg;
  wire [7:0] fall = ~sync2_reg & prev_reg;
  wire [7:0] chg = rise | fall;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      sync1_reg <= i_pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire two_ph_g1 = i_mode_g1[1];
  wire two_ph_g3 = i_mode_g3[1];

  // Quadrature step/direction for one pair; A=a, B=b
  function [1:0] quad;
    input edge4;
    input a_now;
    input b_now;
    input a_chg;
    input b_chg;
    reg up;
    begin
      up = 1'b0;
      // B edge: up when A already sits at the new B level, so A led
      if (b_chg)
        up = (a_now != b_now) ? 1'b0 : 1'b1;
      // A edge: up when A moves away from B, so A leads
      if (a_chg)
        up = (a_now == b_now) ? 1'b0 : 1'b1;
      // Both phases changing in one cycle is an illegal transition: dropped
      if (a_chg && b_chg)
        quad = 2'h0;
      else if (edge4)
        quad = {a_chg | b_chg, up};
      else
        quad = {b_chg, up};
    end
  endfunction

  // Group 1 pins 0/1 and group 3 pins 3/4 form the A/B pairs
  // A mode change is not an edge: it takes effect at the next pin edge
  wire [1:0] q1;
  wire [1:0] q3;
  assign q1 = quad(i_mode_g1 == `FC_MODE_EDGE4, sync2_reg[0], sync2_reg[1],
    chg[0], chg[1]);
  assign q3 = quad(i_mode_g3 == `FC_MODE_EDGE4, sync2_reg[3], sync2_reg[4],
    chg[3], chg[4]);

  // Lane availability: small variant lacks pins 6/7 as counters; group 2/4 lost when used as Z clear
  wire [5:0] avail;
  // A lane that is not available never steps and never reports a match,
  // so a stale preset on it cannot drive an output.
  assign avail[0] = 1'b1;
  assign avail[1] = !(two_ph_g1 && i_z_clear_en_g1);
  assign avail[2] = 1'b1;
  assign avail[3] = !(two_ph_g3 && i_z_clear_en_g3);
  assign avail[4] = (SMALL_VARIANT == 0);
  assign avail[5] = (SMALL_VARIANT == 0);

  reg [5:0] step;
  reg [5:0] up;
  reg [5:0] clr;
  always @* begin
    step = 6'h00;
    up = 6'h3F;
    clr = i_soft_clear;
    // Group 1 and group 3 lanes take any of the four modes
    case (i_mode_g1)
      `FC_MODE_ADD: step[0] = rise[0];
      `FC_MODE_UPDN: begin
        step[0] = rise[0];
        up[0] = sync2_reg[1];
      end
      default: begin
        step[0] = q1[1];
        up[0] = q1[0];
      end
    endcase
    case (i_mode_g3)
      `FC_MODE_ADD: step[2] = rise[3];
      `FC_MODE_UPDN: begin
        step[2] = rise[3];
        up[2] = sync2_reg[4];
      end
      default: begin
        step[2] = q3[1];
        up[2] = q3[0];
      end
    endcase
    // Group 2/4: adding counter on pin 2/5 unless that pin is the Z clear
    if (two_ph_g1 && i_z_clear_en_g1)
      clr[0] = clr[0] | rise[2];
    else
      step[1] = rise[2];
    if (two_ph_g3 && i_z_clear_en_g3)
      clr[2] = clr[2] | rise[5];
    else
      step[3] = rise[5];
    // Lanes 4/5 only ever add; the small variant masks them off through avail
    step[4] = rise[6];
    step[5] = rise[7];
    step = step & avail & i_enable;
  end

  wire [6*W-1:0] lane_val;
  wire [5:0] lane_match;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : lane
      fast_count_lane #(.W(W)) u_lane (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_step(step[g]),
        .i_up(up[g]),
        .i_clear(clr[g]),
        .i_preset(i_preset[g*W +: W]),
        .o_value(lane_val[g*W +: W]),
        .o_match(lane_match[g])
      );
    end
  endgenerate

  reg [5:0] match_prev_reg;
  wire [5:0] hit = lane_match & ~match_prev_reg & i_enable & avail;
  // Interrupt action falls back to the output when ladder is not selected
  wire [5:0] use_irq = i_action & {6{i_ladder_lang}};
  wire [5:0] set_irq;
  wire [5:0] set_out;

  // Only a fresh match acts: a value parked on the preset fires once, not every cycle
  generate
    for (g = 0; g < 6; g = g + 1) begin : action
      // Each lane routes its match to either the interrupt pulse or the latched output
      assign set_irq[g] = hit[g] & use_irq[g];
      assign set_out[g] = hit[g] & ~use_irq[g];
    end
  endgenerate

  // Counter values are registered again so every output comes from a flip-flop
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_prev_reg <= 6'h00;
      o_value <= {6*W{1'b0}};
    end else begin
      match_prev_reg <= lane_match;
      o_value <= lane_val;
    end
  end

  // Overflow and underflow are plain wraps here and fire no action
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmp_out <= 6'h00;
      o_irq <= 6'h00;
    end else begin
      o_irq <= set_irq;
      // Output latches on; a new match wins over a release in the same cycle
      o_cmp_out <= (o_cmp_out & ~i_out_release) | set_out;
    end
  end
endmodule // fast_count_block
`default_nettype wire

/* File: testbench/fast_count_block_monitor.sv */
/* Port checker for fast_count_block. Assumes one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module fast_count_block_monitor #(parameter W = 32) (
  input wire logic i_clk, i_rst_b, i_ladder_lang,
  input wire logic [7:0] i_pins,
  input wire logic [1:0] i_mode_g1,
  input wire logic [5:0] i_soft_clear, i_action, i_out_release, o_cmp_out, o_irq,
  input wire logic [6*W-1:0] i_preset, o_value
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire [W-1:0] v0 = o_value[W-1:0];
  chk_step_dir: assert property ($changed(v0) && i_mode_g1 < 2'h2 && !i_soft_clear[0] |->
    v0 == $past(v0) + ((i_mode_g1 == 2'h1 && !i_pins[1]) ? 32'hFFFFFFFF : 32'h1)) else $error("bad step");
  chk_irq_ladder: assert property (|o_irq |-> i_ladder_lang) else $error("irq off ladder");
  chk_irq_pulse: assert property (o_irq[0] |=> !o_irq[0]) else $error("irq too long");
  chk_idle_hold: assert property (($stable(i_pins) && i_soft_clear == 6'h00) [*5] |=> $stable(o_value))
    else $error("idle count");
  chk_match_hit: assert property ($rose(o_cmp_out[0]) |-> v0 == i_preset[W-1:0]) else $error("off target");
  chk_out_action: assert property ($rose(o_cmp_out[0]) |-> !(i_action[0] && i_ladder_lang)) else $error("act");
  chk_out_release: assert property ($fell(o_cmp_out[0]) |-> $past(i_out_release[0])) else $error("drop");
  chk_clear_zero: assert property (i_soft_clear[0] [*2] |=> v0 == 32'h0) else $error("clear");
endmodule // fast_count_block_monitor
bind fast_count_block fast_count_block_monitor #(.W(W)) fast_count_block_monitor_inst (.*);
`default_nettype wire

/* File: testbench/pulse_source.sv */
/* Field pulse source on pins 0..7. Assumes calls start at a falling edge of i_clk. */
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input wire logic i_clk,
  output var logic [7:0] o_pins
);
  logic [1:0] q = 2'h0;
  initial o_pins = 8'h00;
  task automatic quad(input logic up, input int n);
    repeat (n) begin
      q = up ? q + 2'h1 : q - 2'h1;
      o_pins[1:0] = {q[1], q[1] ^ q[0]};
      o_pins[4:3] = {q[1], q[1] ^ q[0]};
      repeat (4) @(negedge i_clk);
    end
  endtask
  // Four cycles per level keeps clear of the three-cycle minimum
  task automatic pulse(input logic [7:0] m, input int n);
    repeat (n) begin
      o_pins = o_pins | m;
      repeat (4) @(negedge i_clk);
      o_pins = o_pins & ~m;
      repeat (4) @(negedge i_clk);
    end
  endtask
endmodule // pulse_source
`default_nettype wire

/* File: testbench/fast_count_block_test.sv */
/* Bench for fast_count_block with pulse_source. Assumes the large variant. */
`timescale 1ns/1ps
`default_nettype none
module fast_count_block_test;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_ladder_lang = 1'b0, i_z_clear_en_g1 = 1'b0;
  logic [1:0] i_mode_g1 = 2'h0, i_mode_g3 = 2'h0;
  logic [5:0] i_soft_clear = 6'h00, i_action = 6'h00, i_out_release = 6'h00, o_cmp_out, o_irq;
  logic [191:0] i_preset = {6{32'hFFFFFFFF}}, o_value;
  wire [7:0] pins;
  int n_mismatch = 0, checks = 0, n_irq = 0;
  logic [34:0] rows [7] = '{{2'h0, 1'b1, 32'h3}, {2'h1, 1'b1, 32'h3}, {2'h1, 1'b0, 32'hFFFFFFFD},
    {2'h2, 1'b1, 32'h4}, {2'h2, 1'b0, 32'hFFFFFFFC}, {2'h3, 1'b1, 32'h8}, {2'h3, 1'b0, 32'hFFFFFFF8}};
  pulse_source pulse_source_inst (.i_clk(i_clk), .o_pins(pins));
  fast_count_block fast_count_block_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(pins), .i_mode_g1(i_mode_g1),
    .i_mode_g3(i_mode_g3), .i_z_clear_en_g1(i_z_clear_en_g1), .i_z_clear_en_g3(1'b0), .i_enable(6'h3F),
    .i_action(i_action), .i_ladder_lang(i_ladder_lang), .i_soft_clear(i_soft_clear), .i_preset(i_preset),
    .i_out_release(i_out_release), .o_value(o_value), .o_cmp_out(o_cmp_out), .o_irq(o_irq));
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_irq[0] === 1'b1) n_irq <= n_irq + 1;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Clear is held long enough for the registered value to settle at zero
  task automatic clr();
    i_soft_clear = 6'h3F;
    repeat (4) @(negedge i_clk);
    i_soft_clear = 6'h00;
    repeat (6) @(negedge i_clk);
  endtask
  initial begin
    #1ms;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    @(negedge i_clk);
    chk("reset value", o_value[31:0], 32'h0);
    for (int r = 0; r < 7; r++) begin
      i_mode_g1 = rows[r][34:33];
      i_mode_g3 = rows[r][34:33];
      pulse_source_inst.o_pins[1] = rows[r][32] && rows[r][34:33] == 2'h1;
      pulse_source_inst.o_pins[4] = rows[r][32] && rows[r][34:33] == 2'h1;
      clr();
      if (rows[r][34]) pulse_source_inst.quad(rows[r][32], 8);
      else pulse_source_inst.pulse(8'h09, 3);
      repeat (8) @(negedge i_clk);
      chk("lane 0 value", o_value[31:0], rows[r][31:0]);
      chk("lane 2 value", o_value[95:64], rows[r][31:0]);
    end
    chk("output after wrap", o_cmp_out[0], 1'b1);
    i_out_release = 6'h3F;
    repeat (2) @(negedge i_clk);
    i_out_release = 6'h00;
    chk("output released", o_cmp_out[0], 1'b0);
    i_mode_g1 = 2'h3;
    i_z_clear_en_g1 = 1'b1;
    clr();
    pulse_source_inst.quad(1'b1, 4);
    repeat (4) @(negedge i_clk);
    chk("quad count", o_value[31:0], 32'h4);
    pulse_source_inst.pulse(8'h04, 1);
    chk("z clear", o_value[31:0], 32'h0);
    i_mode_g1 = 2'h0;
    i_z_clear_en_g1 = 1'b0;
    i_preset[31:0] = 32'h2;
    i_action[0] = 1'b1;
    i_ladder_lang = 1'b1;
    clr();
    pulse_source_inst.pulse(8'hC1, 3);
    chk("irq pulses", n_irq, 1);
    chk("no output on irq", o_cmp_out[0], 1'b0);
    chk("lane 5 value", o_value[191:160], 32'h3);
    i_ladder_lang = 1'b0;
    clr();
    pulse_source_inst.pulse(8'h01, 3);
    chk("output action", o_cmp_out[0], 1'b1);
    chk("irq held off", n_irq, 1);
    i_rst_b = 1'b0;
    @(negedge i_clk);
    chk("mid-run reset value", o_value[31:0], 32'h0);
    chk("mid-run reset output", o_cmp_out[0], 1'b0);
    i_rst_b = 1'b1;
    pulse_source_inst.pulse(8'h01, 1);
    chk("count after reset", o_value[31:0], 32'h1);
    finish_test();
  end
endmodule // fast_count_block_test
`default_nettype wire
